// *** hw/lcd_column_driver.sv ***
// Purpose: 80-column lcd column driver with nibble input and cascade
// Assumes: all pin inputs are asynchronous to I_CORE_CLK and much slower
// Notes: column levels are 2-bit selection codes, two bits per column
`timescale 1ns/1ps

// Notes on behaviour
// - nibble captured on shift clock falling edge
// - latch pulse falling edge loads line register
// - columns update from new line one core cycle after the line register, held while frozen with blank high
// - nibbles accepted only while enable low
// - cascade output enables next driver in chain
// - blank low forces all columns level A
// - high pixel selected, low non-selected
// - four level codes, pair chosen by data
// - phase alternates polarity within each pair
// - direction input picks first or last column
// - standby when not selected for loading
module lcd_column_driver #(
   parameter int COLUMNS = lcd_column_pkg::COLUMNS
) (
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   // controller pins
   input wire logic I_NIBBLE_SHIFT_CLOCK,
   input wire logic I_LINE_LATCH_PULSE,
   input wire logic [3:0] I_PIXEL_NIBBLE,
   input wire logic I_AC_PHASE,
   input wire logic I_FILL_DIRECTION_SELECT,
   input wire logic I_ENABLE_N,
   input wire logic I_BLANK_N,
   // cascade and drive outputs
   output logic O_CASCADE_N,
   output logic O_STANDBY,
   output logic [2*COLUMNS-1:0] O_COLUMN_OUTPUTS,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   // pin synchronisers, two stages each
   logic [8:0] pin_meta;
   logic [8:0] pin_sync;
   logic shift_clk_prev;
   logic latch_prev;
   logic shift_fall;
   logic latch_fall;
   logic [3:0] nibble_in;
   logic phase;
   logic fill_reverse;
   logic enable_n;
   logic blank_n;

   // line assembly state
   logic [COLUMNS-1:0] collect_line;
   logic [COLUMNS-1:0] line_reg;
   logic [lcd_column_pkg::COUNT_W-1:0] nibble_count;
   logic [lcd_column_pkg::COUNT_W-1:0] write_index;
   logic line_full;
   logic latch_pending;
   logic latch_now;
   logic overrun;
   logic [15:0] line_total;

   // buffer handshakes
   lcd_column_pkg::nibble_s buf_in;
   lcd_column_pkg::nibble_s buf_out;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;

   // register state
   logic [2:0] ctrl;
   logic wr_pending;
   logic [7:0] wr_addr;
   logic [31:0] next_rdata;
   logic bus_access;

   // two flip-flops before anything reads a pin
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         pin_meta <= 9'h180;
         pin_sync <= 9'h180;
      end else begin
         pin_meta <= {I_BLANK_N, I_ENABLE_N, I_LINE_LATCH_PULSE,
                      I_NIBBLE_SHIFT_CLOCK, I_FILL_DIRECTION_SELECT,
                      I_AC_PHASE, I_PIXEL_NIBBLE[2:0]};
         pin_sync <= pin_meta;
      end
   end

   // top data bit kept in its own pair of stages
   logic nib3_meta;
   logic nib3_sync;
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         nib3_meta <= 1'b0;
         nib3_sync <= 1'b0;
      end else begin
         nib3_meta <= I_PIXEL_NIBBLE[3];
         nib3_sync <= nib3_meta;
      end
   end

   // names for the synchronised pins
   assign nibble_in = {nib3_sync, pin_sync[2:0]};
   assign phase = pin_sync[3];
   assign fill_reverse = pin_sync[4];
   assign enable_n = pin_sync[7];
   assign blank_n = pin_sync[8];

   // falling-edge detection on the synchronised clocks
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         shift_clk_prev <= 1'b0;
         latch_prev <= 1'b0;
      end else begin
         shift_clk_prev <= pin_sync[5];
         latch_prev <= pin_sync[6];
      end
   end

   assign shift_fall = shift_clk_prev && !pin_sync[5];
   assign latch_fall = latch_prev && !pin_sync[6];

   // a nibble is offered only while enabled and the line is not full
   assign buf_in.pixels = nibble_in;
   assign buf_in.fill_reverse = fill_reverse;
   assign buf_in_valid = shift_fall && !enable_n && !line_full;

   // two-entry buffer between the pins and the line assembler
   pair_buffer #(
      .WIDTH($bits(lcd_column_pkg::nibble_s)),
      .DEPTH(2)
   ) u_nibble_buffer (
      .i_clk(I_CORE_CLK),
      .i_reset_n(I_RESET_N),
      .i_in_valid(buf_in_valid),
      .i_in_data(buf_in),
      .o_in_ready(buf_in_ready),
      .o_out_valid(buf_out_valid),
      .o_out_data(buf_out),
      .i_out_ready(buf_out_ready)
   );

   // the assembler pauses in the cycle the line moves to the output
   assign latch_now = latch_pending && !buf_out_valid;
   assign buf_out_ready = !latch_now;

   // accepted-nibble count, stops at a full line, clears on latch
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         nibble_count <= '0;
         line_full <= 1'b0;
      end else if (latch_fall) begin
         nibble_count <= '0;
         line_full <= 1'b0;
      end else if (buf_in_valid && buf_in_ready) begin
         nibble_count <= nibble_count + 1'b1;
         line_full <= (nibble_count == lcd_column_pkg::NIBBLE_LAST);
      end
   end

   // a nibble lost to a full buffer is flagged, set wins over clear
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         overrun <= 1'b0;
      end else if (buf_in_valid && !buf_in_ready) begin
         overrun <= 1'b1;
      end else if (wr_pending && wr_addr == lcd_column_pkg::CTRL_OFFSET &&
                   HWDATA[lcd_column_pkg::CTRL_CLR_OVERRUN_BIT]) begin
         overrun <= 1'b0;
      end
   end

   // drained nibbles go to consecutive slots of the collect line
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         write_index <= '0;
      end else if (latch_now) begin
         write_index <= '0;
      end else if (buf_out_valid && buf_out_ready) begin
         write_index <= write_index + 1'b1;
      end
   end

   // place nibble bits forward from the first column or backward
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         collect_line <= '0;
      end else if (buf_out_valid && buf_out_ready) begin
         for (int b = 0; b < lcd_column_pkg::NIBBLE_W; b++) begin
            if (buf_out.fill_reverse) begin
               collect_line[COLUMNS - 1 - (int'(write_index) * 4 + b)] <=
                  buf_out.pixels[b];
            end else begin
               collect_line[int'(write_index) * 4 + b] <=
                  buf_out.pixels[b];
            end
         end
      end
   end

   // a latch edge waits until buffered nibbles have been placed
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         latch_pending <= 1'b0;
      end else if (latch_fall) begin
         latch_pending <= 1'b1;
      end else if (latch_now) begin
         latch_pending <= 1'b0;
      end
   end

   // the line register takes the whole row at once
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         line_reg <= '0;
      end else if (latch_now) begin
         line_reg <= collect_line;
      end
   end

   // count of lines moved to the outputs
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         line_total <= '0;
      end else if (latch_now) begin
         line_total <= line_total + 1'b1;
      end
   end

   // per-column level selection from data, phase and blanking
   function automatic lcd_column_pkg::level_e pick_level(
      input logic pixel,
      input logic ac,
      input logic blank
   );
      lcd_column_pkg::level_e lvl;
      if (!blank) begin
         lvl = lcd_column_pkg::SEL_LEVEL_A;
      end else if (pixel) begin
         lvl = ac ? lcd_column_pkg::SEL_LEVEL_A
                  : lcd_column_pkg::SEL_LEVEL_B;
      end else begin
         lvl = ac ? lcd_column_pkg::UNSEL_LEVEL_A
                  : lcd_column_pkg::UNSEL_LEVEL_B;
      end
      return lvl;
   endfunction

   // drive register: follows the line register, held while frozen with blank high
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         O_COLUMN_OUTPUTS <= '0;
      end else if (!ctrl[lcd_column_pkg::CTRL_FREEZE_BIT] || !blank_n) begin
         for (int c = 0; c < COLUMNS; c++) begin
            O_COLUMN_OUTPUTS[2*c +: 2] <=
               pick_level(line_reg[c], phase, blank_n);
         end
      end
   end

   // cascade enable for the next driver once this line is full
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         O_CASCADE_N <= 1'b1;
      end else begin
         O_CASCADE_N <= !line_full;
      end
   end

   // standby whenever this driver is not loading
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         O_STANDBY <= 1'b1;
      end else begin
         O_STANDBY <= enable_n || line_full ||
                      ctrl[lcd_column_pkg::CTRL_FORCE_STANDBY_BIT];
      end
   end

   // ahb-lite: zero wait states, always okay
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign bus_access = HSEL && HREADY &&
                       HTRANS == lcd_column_pkg::HTRANS_NONSEQ;

   // write address phase is remembered for the data phase
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         wr_pending <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pending <= bus_access && HWRITE && HSIZE == 3'h2;
         wr_addr <= HADDR[7:0];
      end
   end

   // control register write in the data phase
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         ctrl <= lcd_column_pkg::CTRL_RESET;
      end else if (wr_pending && wr_addr == lcd_column_pkg::CTRL_OFFSET) begin
         ctrl <= {HWDATA[lcd_column_pkg::CTRL_FORCE_STANDBY_BIT], 1'b0,
                  HWDATA[lcd_column_pkg::CTRL_FREEZE_BIT]};
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (HADDR[7:0])
         lcd_column_pkg::CTRL_OFFSET: begin
            next_rdata[2:0] = ctrl;
         end
         lcd_column_pkg::STATUS_OFFSET: begin
            next_rdata[lcd_column_pkg::STATUS_COUNT_LSB +: 5] = nibble_count;
            next_rdata[lcd_column_pkg::STATUS_FULL_BIT] = line_full;
            next_rdata[lcd_column_pkg::STATUS_STANDBY_BIT] = O_STANDBY;
            next_rdata[lcd_column_pkg::STATUS_OVERRUN_BIT] = overrun;
            next_rdata[lcd_column_pkg::STATUS_PENDING_BIT] = latch_pending;
         end
         lcd_column_pkg::LINES_OFFSET: begin
            next_rdata[15:0] = line_total;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data captured at the address phase, shown in the data phase
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         HRDATA <= 32'h0000_0000;
      end else if (bus_access && !HWRITE) begin
         HRDATA <= next_rdata;
      end
   end
endmodule // lcd_column_driver

// *** hw/lcd_column_pkg.sv ***
// Purpose: shared constants and types for the 80-column lcd driver
// Assumes: 32-bit ahb-lite register bus, one core clock
// Notes: level codes are the drive selections handed to the analog side
package lcd_column_pkg;
   // line geometry
   localparam int COLUMNS = 80;
   localparam int NIBBLE_W = 4;
   localparam int NIBBLES_PER_LINE = COLUMNS / NIBBLE_W;
   localparam int COUNT_W = 5;
   localparam logic [4:0] NIBBLE_LAST = 5'h13;

   // register byte addresses
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] LINES_OFFSET = 8'h08;

   // control register fields and reset value
   localparam int CTRL_FREEZE_BIT = 0;
   localparam int CTRL_CLR_OVERRUN_BIT = 1;
   localparam int CTRL_FORCE_STANDBY_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // status register fields
   localparam int STATUS_COUNT_LSB = 0;
   localparam int STATUS_FULL_BIT = 5;
   localparam int STATUS_STANDBY_BIT = 6;
   localparam int STATUS_OVERRUN_BIT = 7;
   localparam int STATUS_PENDING_BIT = 8;

   // ahb transfer type for a non-sequential access
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // drive level selections: two selected, two non-selected
   typedef enum logic [1:0] {
      SEL_LEVEL_A = 2'h0,
      SEL_LEVEL_B = 2'h1,
      UNSEL_LEVEL_A = 2'h2,
      UNSEL_LEVEL_B = 2'h3
   } level_e;

   // one accepted nibble with the fill direction it was taken under
   typedef struct packed {
      logic [NIBBLE_W-1:0] pixels;
      logic fill_reverse;
   } nibble_s;
endpackage

// *** hw/pair_buffer.sv ***
// Purpose: two-entry valid/ready buffer for the nibble stream
// Assumes: synchronous active-low reset on the shared core clock
// Notes: full and empty are exact; a stalled drain fills both entries
`timescale 1ns/1ps
module pair_buffer #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] fill;
   logic push;
   logic pop;

   // handshake terms
   assign o_in_ready = (fill != DEPTH_CNT);
   assign o_out_valid = (fill != '0);
   assign o_out_data = store[rd_ptr];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // entry storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         store[wr_ptr] <= i_in_data;
      end
   end

   // pointers wrap at the configured depth
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         fill <= '0;
      end else if (push && !pop) begin
         fill <= fill + 1'b1;
      end else if (pop && !push) begin
         fill <= fill - 1'b1;
      end
   end
endmodule // pair_buffer

// *** sim/lcd_ctrl_model.sv ***
// Purpose: behavioural lcd controller driving the pin link
// Assumes: pins change just after a core clock rising edge
// Notes: data lines show the inverse once their hold has run out
`timescale 1ns/1ps
module lcd_ctrl_model (
   // core clock
   input wire logic i_clk,
   // pin link
   output logic o_shift,
   output logic o_latch,
   output logic [3:0] o_nibble,
   output logic o_enable_n
);
   // idle pin levels, chip disabled
   initial begin
      o_shift = 1'b0;
      o_latch = 1'b0;
      o_nibble = 4'h0;
      o_enable_n = 1'b1;
   end
   // one nibble held around its falling shift edge
   task automatic put_nibble(input logic [3:0] d, input int gap);
      @(posedge i_clk);
      o_nibble <= d;
      o_shift <= 1'b1;
      repeat (gap) @(posedge i_clk);
      o_shift <= 1'b0;
      repeat (gap) @(posedge i_clk);
      o_nibble <= ~d;
   endtask
   // line latch pulse, falling edge moves the line
   task automatic pulse_latch();
      @(posedge i_clk);
      o_latch <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_latch <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
   // chip enable level
   task automatic set_enable(input logic v);
      @(posedge i_clk);
      o_enable_n <= v;
   endtask
endmodule // lcd_ctrl_model

// *** sim/lcd_column_driver_chk.sv ***
// Purpose: port checker for the lcd column driver
// Assumes: one core clock domain, synchronous active-low reset
// Notes: pin paths allow up to six core cycles of delay
`timescale 1ns/1ps
module lcd_column_driver_chk #(
   parameter int COLUMNS = 80
) (
   // clock, reset and pins
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic I_LINE_LATCH_PULSE,
   input wire logic I_AC_PHASE,
   input wire logic I_ENABLE_N,
   input wire logic I_BLANK_N,
   // outputs watched
   input wire logic O_CASCADE_N,
   input wire logic O_STANDBY,
   input wire logic [2*COLUMNS-1:0] O_COLUMN_OUTPUTS,
   input wire logic HREADYOUT,
   input wire logic HRESP
);
   logic [COLUMNS-1:0] phase_bits;
   logic [7:0] since_latch;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   // low bit of every column code is the inverse of the phase
   always_comb begin
      for (int c = 0; c < COLUMNS; c++) begin
         phase_bits[c] = O_COLUMN_OUTPUTS[2*c];
      end
   end
   // cycles since the latch pin last fell, counted while it stays low
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N || I_LINE_LATCH_PULSE) since_latch <= 8'h00;
      else if (since_latch != 8'hFF) since_latch <= since_latch + 8'h01;
   end
   a_bus_okay: assert property (HRESP == 1'b0 && HREADYOUT == 1'b1)
      else $error("bus answer not okay and ready");
   a_blank_forces: assert property (
      !I_BLANK_N [*6] |-> O_COLUMN_OUTPUTS == '0)
      else $error("columns not forced to level a");
   a_phase_high: assert property (
      (I_BLANK_N && I_AC_PHASE) [*6] |-> phase_bits == '0)
      else $error("phase high gave odd level code");
   a_phase_low: assert property (
      (I_BLANK_N && !I_AC_PHASE) [*6] |-> &phase_bits)
      else $error("phase low gave even level code");
   a_idle_standby: assert property (I_ENABLE_N [*5] |-> O_STANDBY)
      else $error("no standby while disabled");
   a_full_standby: assert property (
      $fell(O_CASCADE_N) |-> ##[0:3] O_STANDBY)
      else $error("no standby after full line");
   a_cascade_release: assert property (
      $fell(I_LINE_LATCH_PULSE) && !O_CASCADE_N |-> ##[1:10] O_CASCADE_N)
      else $error("cascade not released after latch");
   a_cascade_cause: assert property (
      $rose(O_CASCADE_N) |-> since_latch < 8'h0C)
      else $error("cascade rose without a latch");
endmodule // lcd_column_driver_chk

bind lcd_column_driver lcd_column_driver_chk #(.COLUMNS(COLUMNS)) chk_i (
   .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N),
   .I_LINE_LATCH_PULSE(I_LINE_LATCH_PULSE), .I_AC_PHASE(I_AC_PHASE),
   .I_ENABLE_N(I_ENABLE_N), .I_BLANK_N(I_BLANK_N),
   .O_CASCADE_N(O_CASCADE_N), .O_STANDBY(O_STANDBY),
   .O_COLUMN_OUTPUTS(O_COLUMN_OUTPUTS), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP));

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the lcd column driver
// Assumes: controller model drives shift, latch, data and enable pins, bench drives the bus, phase, direction and blank
// Notes: random lines from a fixed seed, one hand-made line first
`timescale 1ns/1ps
module testbench;
   logic clk, rst_n, phase, dir, blank_n, hwrite, hreadyout, hresp;
   logic shift, latch, en_n, cas_n, stby;
   logic [3:0] nib;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [159:0] cols;
   logic [79:0] line;
   int bad_count = 0;
   int check_count = 0;
   // core clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   lcd_ctrl_model lcd_ctrl_model_i (.i_clk(clk), .o_shift(shift),
      .o_latch(latch), .o_nibble(nib), .o_enable_n(en_n));
   lcd_column_driver lcd_column_driver_i (.I_CORE_CLK(clk),
      .I_RESET_N(rst_n), .I_NIBBLE_SHIFT_CLOCK(shift),
      .I_LINE_LATCH_PULSE(latch), .I_PIXEL_NIBBLE(nib),
      .I_AC_PHASE(phase), .I_FILL_DIRECTION_SELECT(dir),
      .I_ENABLE_N(en_n), .I_BLANK_N(blank_n), .O_CASCADE_N(cas_n),
      .O_STANDBY(stby), .O_COLUMN_OUTPUTS(cols), .HSEL(1'b1),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp));
   // expected level codes of a whole line
   function automatic logic [159:0] exp_cols(logic [79:0] l, logic ph);
      logic [159:0] r;
      for (int c = 0; c < 80; c++) begin
         r[2*c +: 2] = l[c] ? (ph ? 2'h0 : 2'h1) : (ph ? 2'h2 : 2'h3);
      end
      return r;
   endfunction
   // nibble k that fills the columns of a line
   function automatic logic [3:0] nib_of(logic [79:0] l, logic d, int k);
      for (int b = 0; b < 4; b++) begin
         nib_of[b] = d ? l[79-(4*k+b)] : l[4*k+b];
      end
   endfunction
   task automatic idle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk_cols(logic [159:0] e);
      check_count++;
      if (cols !== e) begin
         bad_count++;
         $display("mismatch at %0t: column levels", $time);
      end
   endtask
   task automatic chk_val(logic [31:0] g, logic [31:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // single word transfer, address phase then data phase
   task automatic ahb(logic w, logic [31:0] a, d, output logic [31:0] r);
      @(posedge clk);
      htrans <= lcd_column_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic feed(logic [79:0] l, logic d);
      for (int k = 0; k < 20; k++) begin
         lcd_ctrl_model_i.put_nibble(nib_of(l, d, k), 4 + $urandom_range(3));
      end
   endtask
   // fill, overfill, latch, then view in both phases and blanked
   task automatic run_line(logic [79:0] l, logic d);
      @(posedge clk);
      dir <= d;
      lcd_ctrl_model_i.set_enable(1'b0);
      idle(4);
      chk_val(stby, 0);
      feed(l, d);
      idle(6);
      chk_val(cas_n, 0);
      chk_val(stby, 1);
      lcd_ctrl_model_i.put_nibble(~nib_of(l, d, 0), 4);
      ahb(1'b0, lcd_column_pkg::STATUS_OFFSET, 0, rd);
      chk_val(rd[5], 1);
      chk_val(rd[4:0], 5'h14);
      lcd_ctrl_model_i.pulse_latch();
      idle(4);
      chk_val(cas_n, 1);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         phase <= p[0];
         idle(6);
         chk_cols(exp_cols(l, p[0]));
      end
      @(posedge clk);
      blank_n <= 1'b0;
      idle(6);
      chk_cols('0);
      @(posedge clk);
      blank_n <= 1'b1;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      phase = 1'b0;
      dir = 1'b0;
      blank_n = 1'b1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      void'($urandom(32'hED0123AD));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      idle(4);
      chk_val(cas_n, 1);
      chk_val(stby, 1);
      ahb(1'b0, lcd_column_pkg::CTRL_OFFSET, 0, rd);
      chk_val(rd, 0);
      ahb(1'b0, 32'h0000000C, 0, rd);
      chk_val(rd, 0);
      for (int i = 0; i < 4; i++) begin
         line = {16'($urandom), $urandom, $urandom};
         if (i == 0) line = {20{4'hA}};
         run_line(line, i[0]);
      end
      lcd_ctrl_model_i.set_enable(1'b1);
      feed(~line, 1'b0);
      lcd_ctrl_model_i.pulse_latch();
      idle(4);
      chk_cols(exp_cols(line, 1'b1));
      lcd_ctrl_model_i.set_enable(1'b0);
      ahb(1'b1, lcd_column_pkg::CTRL_OFFSET, 32'h4, rd);
      idle(4);
      chk_val(stby, 1);
      ahb(1'b1, lcd_column_pkg::CTRL_OFFSET, 32'h0, rd);
      idle(4);
      chk_val(stby, 0);
      // freeze holds the columns across a latch, clear bit is not stored
      ahb(1'b1, lcd_column_pkg::CTRL_OFFSET, 32'h3, rd);
      ahb(1'b0, lcd_column_pkg::CTRL_OFFSET, 0, rd);
      chk_val(rd, 32'h1);
      feed(~line, 1'b1);
      lcd_ctrl_model_i.pulse_latch();
      idle(4);
      chk_cols(exp_cols(line, 1'b1));
      ahb(1'b1, lcd_column_pkg::CTRL_OFFSET, 32'h0, rd);
      idle(4);
      chk_cols(exp_cols(~line, 1'b1));
      ahb(1'b0, lcd_column_pkg::LINES_OFFSET, 0, rd);
      chk_val(rd, 32'h6);
      tally_and_finish();
   end
endmodule // testbench
